// ===== uv_pkg.sv
// Overview of operation
// RL1 - Phase starts while its magnitude is below start level and above block level.
// RL2 - General start asserts when the started phases meet the operation selector quorum.
// RL3 - Trip only after full delay with start present and trip generation enabled.
// RL4 - Medium-voltage configuration evaluates line-to-line voltages by default.
// RL5 - Line-to-line mode maps phases to pairs ab, bc and ca.
// RL6 - Operating time is fixed, independent of voltage depth.
// RL7 - Compared quantity is the supplied fundamental magnitude of each voltage.
// RL8 - Operation selector: off, one of three, two of three, all; default off.
// RL9 - Start level in percent, step 1, default 90.
// RL10 - Block level 0 to 20 percent, default 10; below it start is suppressed.
// RL11 - Release hysteresis 1 to 10 percent, default 5, applied on start release.
// RL12 - Start-only bit: 0 gives start and trip, 1 suppresses combined trip; per-phase trips still set.
// RL13 - Operate delay in ms, minimum 50, step 1, default 100.
// RL14 - Each phase has start and trip flags; trip after phase delay expires.
// RL15 - Per-phase trips have no output pin and are read in the status register; only combined trip is an output.
// RL16 - User block input forces all starts and trips inactive.
// RL17 - Combined trip formed from per-phase results and configuration.
// RL18 - Selector sets how many phases must be started or tripped at once.
// RL19 - Phase delay timer clears whenever its start condition drops.
package uv_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int MS_PER_S = 1000;
   localparam int CYCLES_PER_MS = CLK_HZ / MS_PER_S;
   localparam int MAG_W = 16;
   localparam int DLY_W = 16;
   localparam logic [7:0] START_PCT_DEF = 8'h5A;
   localparam logic [7:0] START_PCT_MIN = 8'h1E;
   localparam logic [7:0] START_PCT_MAX = 8'h82;
   localparam logic [7:0] BLOCK_PCT_DEF = 8'h0A;
   localparam logic [7:0] BLOCK_PCT_MAX = 8'h14;
   localparam logic [7:0] HYST_PCT_DEF = 8'h05;
   localparam logic [7:0] HYST_PCT_MIN = 8'h01;
   localparam logic [7:0] HYST_PCT_MAX = 8'h0A;
   localparam logic [15:0] DELAY_MS_DEF = 16'h0064;
   localparam logic [15:0] DELAY_MS_MIN = 16'h0032;
   localparam logic [15:0] DELAY_MS_MAX = 16'hEA60;
   localparam logic [15:0] NOMINAL_DEF = 16'h2710;
   // APB map, one aligned word each
   localparam logic [7:0] OFS_OPER = 8'h00;
   localparam logic [7:0] OFS_START = 8'h04;
   localparam logic [7:0] OFS_BLOCK = 8'h08;
   localparam logic [7:0] OFS_HYST = 8'h0C;
   localparam logic [7:0] OFS_DELAY = 8'h10;
   localparam logic [7:0] OFS_NOMINAL = 8'h14;
   localparam logic [7:0] OFS_STATUS = 8'h18;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h1C;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h20;
   // OPER register fields
   localparam int OPER_SEL_LSB = 0;
   localparam int OPER_START_ONLY_BIT = 2;
   localparam int OPER_LL_BIT = 3;
   localparam logic OPER_LL_DEF = 1'b1;
   // Interrupt bits: 0 general start rise, 1 combined trip rise
   localparam int IRQ_START_BIT = 0;
   localparam int IRQ_TRIP_BIT = 1;
   typedef enum logic [1:0] {
      OP_OFF = 2'b00,
      OP_ONE = 2'b01,
      OP_TWO = 2'b11,
      OP_ALL = 2'b10
   } oper_t;
endpackage : uv_pkg

// ===== uv_phase.sv
module uv_phase #(
   parameter int MAG_W = uv_pkg::MAG_W,
   parameter int DLY_W = uv_pkg::DLY_W,
   parameter int TICK_CYCLES = uv_pkg::CYCLES_PER_MS
) (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic enable,
   input wire logic [MAG_W-1:0] mag,
   input wire logic [MAG_W-1:0] start_lvl,
   input wire logic [MAG_W-1:0] release_lvl,
   input wire logic [MAG_W-1:0] block_lvl,
   input wire logic [DLY_W-1:0] delay_ms,
   input wire logic ms_tick,
   output logic started,
   output logic tripped
);
   logic start_reg, start_next;
   logic [DLY_W-1:0] cnt_reg, cnt_next;
   logic trip_reg, trip_next;
   logic above_block;

   assign above_block = mag > block_lvl;

   always_comb begin
      start_next = start_reg;
      cnt_next = cnt_reg;
      if (!enable || !above_block) begin
         start_next = 1'b0;
      end else if (start_reg) begin
         // Release needs the magnitude back above start plus hysteresis
         start_next = mag < release_lvl; // see RL11
      end else begin
         start_next = mag < start_lvl; // see RL1
      end
      if (!start_next) begin
         cnt_next = '0; // see RL19
      end else if (ms_tick && cnt_reg <= delay_ms) begin
         // First tick may come at once, so one extra tick covers the whole delay
         cnt_next = cnt_reg + 1'b1; // see RL6
      end
      trip_next = start_next && cnt_next > delay_ms; // see RL14
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         start_reg <= 1'b0;
         cnt_reg <= '0;
         trip_reg <= 1'b0;
      end else begin
         start_reg <= start_next;
         cnt_reg <= cnt_next;
         trip_reg <= trip_next;
      end
   end

   assign started = start_reg;
   assign tripped = trip_reg;

   property p_trip_needs_count;
      @(posedge clk) disable iff (!rst_n)
         tripped |-> started && cnt_reg > delay_ms;
   endproperty
   a_trip_needs_count: assert property (p_trip_needs_count) // see RL3
      else $error("Phase trip without full delay");

   property p_drop_clears;
      @(posedge clk) disable iff (!rst_n)
         $fell(started) |-> cnt_reg == '0 && !tripped;
   endproperty
   a_drop_clears: assert property (p_drop_clears) // see RL19
      else $error("Timer not cleared on start drop");

   property p_low_block;
      @(posedge clk) disable iff (!rst_n)
         !above_block |=> !started;
   endproperty
   a_low_block: assert property (p_low_block) // see RL10
      else $error("Start below block level");
endmodule : uv_phase

// ===== undervoltage_element.sv
module undervoltage_element #(
   parameter int MAG_W = uv_pkg::MAG_W,
   parameter int DLY_W = uv_pkg::DLY_W,
   parameter int TICK_CYCLES = uv_pkg::CYCLES_PER_MS
) (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic [MAG_W-1:0] PHASE_A_FUND_MAG,
   input wire logic [MAG_W-1:0] PHASE_B_FUND_MAG,
   input wire logic [MAG_W-1:0] PHASE_C_FUND_MAG,
   input wire logic [MAG_W-1:0] PAIR_AB_FUND_MAG,
   input wire logic [MAG_W-1:0] PAIR_BC_FUND_MAG,
   input wire logic [MAG_W-1:0] PAIR_CA_FUND_MAG,
   input wire logic USER_BLOCK_IN,
   input wire logic PSEL,
   input wire logic PENABLE,
   input wire logic PWRITE,
   input wire logic [7:0] PADDR,
   input wire logic [31:0] PWDATA,
   output logic [31:0] PRDATA,
   output logic PREADY,
   output logic PSLVERR,
   output logic PHASE_A_START,
   output logic PHASE_B_START,
   output logic PHASE_C_START,
   output logic ANY_PHASE_START,
   output logic COMBINED_TRIP,
   output logic IRQ
);
   logic [1:0] oper_reg, oper_next;
   logic start_only_reg, start_only_next;
   logic ll_reg, ll_next;
   logic [7:0] start_pct_reg, start_pct_next;
   logic [7:0] block_pct_reg, block_pct_next;
   logic [7:0] hyst_pct_reg, hyst_pct_next;
   logic [DLY_W-1:0] delay_reg, delay_next;
   logic [MAG_W-1:0] nominal_reg, nominal_next;
   logic [1:0] irq_stat_reg, irq_stat_next;
   logic [1:0] irq_mask_reg, irq_mask_next;
   logic [31:0] rdata_reg, rdata_next;
   logic [15:0] tick_cnt_reg, tick_cnt_next;
   logic [2:0] gstart_reg, gstart_next;
   logic gtrip_reg, gtrip_next;
   logic ms_tick;
   logic enable;
   logic wr_acc, rd_acc, addr_ok;
   logic [MAG_W-1:0] start_lvl, release_lvl, block_lvl;
   logic [MAG_W-1:0] mag [3];
   logic [2:0] ph_start, ph_trip;
   logic [1:0] n_start, n_trip;
   logic need_ok_start, need_ok_trip;
   logic start_ev, trip_ev;

   function automatic logic [MAG_W-1:0] pct_of(input logic [MAG_W-1:0] nom,
                                              input logic [8:0] pct);
      logic [MAG_W+8:0] prod;
      prod = nom * pct;
      pct_of = MAG_W'(prod / 100);
   endfunction : pct_of

   function automatic logic quorum(input logic [1:0] n, input logic [1:0] sel);
      quorum = 1'b0;
      unique case (sel)
         uv_pkg::OP_OFF: quorum = 1'b0;
         uv_pkg::OP_ONE: quorum = n >= 2'd1;
         uv_pkg::OP_TWO: quorum = n >= 2'd2;
         uv_pkg::OP_ALL: quorum = n == 2'd3;
      endcase
   endfunction : quorum

   // Register bus: zero wait states, unmapped addresses answer with an error
   assign PREADY = 1'b1;
   assign wr_acc = PSEL && PENABLE && PWRITE;
   assign rd_acc = PSEL && !PENABLE && !PWRITE;
   always_comb begin
      addr_ok = 1'b1;
      unique case (PADDR)
         uv_pkg::OFS_OPER, uv_pkg::OFS_START, uv_pkg::OFS_BLOCK, uv_pkg::OFS_HYST,
         uv_pkg::OFS_DELAY, uv_pkg::OFS_NOMINAL, uv_pkg::OFS_STATUS,
         uv_pkg::OFS_IRQ_STAT, uv_pkg::OFS_IRQ_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end
   assign PSLVERR = PSEL && PENABLE && !addr_ok;

   always_comb begin
      oper_next = oper_reg;
      start_only_next = start_only_reg;
      ll_next = ll_reg;
      start_pct_next = start_pct_reg;
      block_pct_next = block_pct_reg;
      hyst_pct_next = hyst_pct_reg;
      delay_next = delay_reg;
      nominal_next = nominal_reg;
      irq_mask_next = irq_mask_reg;
      irq_stat_next = irq_stat_reg;
      rdata_next = rdata_reg;
      if (wr_acc) begin
         unique case (PADDR)
            uv_pkg::OFS_OPER: begin
               oper_next = PWDATA[uv_pkg::OPER_SEL_LSB +: 2]; // see RL8
               start_only_next = PWDATA[uv_pkg::OPER_START_ONLY_BIT]; // see RL12
               ll_next = PWDATA[uv_pkg::OPER_LL_BIT]; // see RL4
            end
            uv_pkg::OFS_START: begin
               // Out-of-range writes are clamped to the setting range
               if (PWDATA[7:0] < uv_pkg::START_PCT_MIN || PWDATA[31:8] != '0) begin
                  start_pct_next = (PWDATA[31:8] != '0) ? uv_pkg::START_PCT_MAX
                                                        : uv_pkg::START_PCT_MIN;
               end else if (PWDATA[7:0] > uv_pkg::START_PCT_MAX) begin
                  start_pct_next = uv_pkg::START_PCT_MAX;
               end else begin
                  start_pct_next = PWDATA[7:0]; // see RL9
               end
            end
            uv_pkg::OFS_BLOCK: begin
               block_pct_next = (PWDATA > 32'(uv_pkg::BLOCK_PCT_MAX)) ?
                                uv_pkg::BLOCK_PCT_MAX : PWDATA[7:0]; // see RL10
            end
            uv_pkg::OFS_HYST: begin
               if (PWDATA > 32'(uv_pkg::HYST_PCT_MAX)) begin
                  hyst_pct_next = uv_pkg::HYST_PCT_MAX;
               end else if (PWDATA[7:0] < uv_pkg::HYST_PCT_MIN) begin
                  hyst_pct_next = uv_pkg::HYST_PCT_MIN;
               end else begin
                  hyst_pct_next = PWDATA[7:0]; // see RL11
               end
            end
            uv_pkg::OFS_DELAY: begin
               if (PWDATA > 32'(uv_pkg::DELAY_MS_MAX)) begin
                  delay_next = DLY_W'(uv_pkg::DELAY_MS_MAX);
               end else if (PWDATA[15:0] < uv_pkg::DELAY_MS_MIN) begin
                  delay_next = DLY_W'(uv_pkg::DELAY_MS_MIN); // see RL13
               end else begin
                  delay_next = DLY_W'(PWDATA[15:0]);
               end
            end
            uv_pkg::OFS_NOMINAL: nominal_next = MAG_W'(PWDATA);
            uv_pkg::OFS_IRQ_STAT: irq_stat_next = irq_stat_reg & ~PWDATA[1:0];
            uv_pkg::OFS_IRQ_MASK: irq_mask_next = PWDATA[1:0];
            default: ;
         endcase
      end
      // New events win over a clear in the same cycle
      irq_stat_next[uv_pkg::IRQ_START_BIT] = irq_stat_next[uv_pkg::IRQ_START_BIT] | start_ev;
      irq_stat_next[uv_pkg::IRQ_TRIP_BIT] = irq_stat_next[uv_pkg::IRQ_TRIP_BIT] | trip_ev;
      if (rd_acc) begin
         rdata_next = '0;
         unique case (PADDR)
            uv_pkg::OFS_OPER: rdata_next[3:0] = {ll_reg, start_only_reg, oper_reg};
            uv_pkg::OFS_START: rdata_next[7:0] = start_pct_reg;
            uv_pkg::OFS_BLOCK: rdata_next[7:0] = block_pct_reg;
            uv_pkg::OFS_HYST: rdata_next[7:0] = hyst_pct_reg;
            uv_pkg::OFS_DELAY: rdata_next[DLY_W-1:0] = delay_reg;
            uv_pkg::OFS_NOMINAL: rdata_next[MAG_W-1:0] = nominal_reg;
            uv_pkg::OFS_STATUS: rdata_next[7:0] = {1'b0, gtrip_reg, ph_trip, gstart_reg};
            uv_pkg::OFS_IRQ_STAT: rdata_next[1:0] = irq_stat_reg;
            uv_pkg::OFS_IRQ_MASK: rdata_next[1:0] = irq_mask_reg;
            default: ;
         endcase
      end
   end

   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         oper_reg <= uv_pkg::OP_OFF;
         start_only_reg <= 1'b0;
         ll_reg <= uv_pkg::OPER_LL_DEF;
         start_pct_reg <= uv_pkg::START_PCT_DEF;
         block_pct_reg <= uv_pkg::BLOCK_PCT_DEF;
         hyst_pct_reg <= uv_pkg::HYST_PCT_DEF;
         delay_reg <= DLY_W'(uv_pkg::DELAY_MS_DEF);
         nominal_reg <= MAG_W'(uv_pkg::NOMINAL_DEF);
         irq_stat_reg <= 2'h0;
         irq_mask_reg <= 2'h0;
         rdata_reg <= 32'h0000_0000;
      end else begin
         oper_reg <= oper_next;
         start_only_reg <= start_only_next;
         ll_reg <= ll_next;
         start_pct_reg <= start_pct_next;
         block_pct_reg <= block_pct_next;
         hyst_pct_reg <= hyst_pct_next;
         delay_reg <= delay_next;
         nominal_reg <= nominal_next;
         irq_stat_reg <= irq_stat_next;
         irq_mask_reg <= irq_mask_next;
         rdata_reg <= rdata_next;
      end
   end
   assign PRDATA = rdata_reg;

   // Millisecond time base
   assign ms_tick = tick_cnt_reg == 16'(TICK_CYCLES - 1);
   always_comb begin
      tick_cnt_next = ms_tick ? 16'h0000 : tick_cnt_reg + 16'h0001;
   end
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         tick_cnt_reg <= 16'h0000;
      end else begin
         tick_cnt_reg <= tick_cnt_next;
      end
   end

   assign enable = oper_reg != uv_pkg::OP_OFF && !USER_BLOCK_IN; // see RL16
   assign start_lvl = pct_of(nominal_reg, {1'b0, start_pct_reg});
   assign release_lvl = pct_of(nominal_reg, 9'({1'b0, start_pct_reg} + {1'b0, hyst_pct_reg}));
   assign block_lvl = pct_of(nominal_reg, {1'b0, block_pct_reg});
   // Pair magnitudes map ab, bc, ca onto phases a, b, c
   assign mag[0] = ll_reg ? PAIR_AB_FUND_MAG : PHASE_A_FUND_MAG; // see RL5
   assign mag[1] = ll_reg ? PAIR_BC_FUND_MAG : PHASE_B_FUND_MAG; // see RL7
   assign mag[2] = ll_reg ? PAIR_CA_FUND_MAG : PHASE_C_FUND_MAG;

   for (genvar i = 0; i < 3; i++) begin : g_phase
      uv_phase #(.MAG_W(MAG_W), .DLY_W(DLY_W), .TICK_CYCLES(TICK_CYCLES)) u_phase (
         .clk(CLK_SYS),
         .rst_n(RST_N),
         .enable(enable),
         .mag(mag[i]),
         .start_lvl(start_lvl),
         .release_lvl(release_lvl),
         .block_lvl(block_lvl),
         .delay_ms(delay_reg),
         .ms_tick(ms_tick),
         .started(ph_start[i]),
         .tripped(ph_trip[i]) // see RL15
      );
   end

   assign n_start = 2'(ph_start[0]) + 2'(ph_start[1]) + 2'(ph_start[2]);
   assign n_trip = 2'(ph_trip[0]) + 2'(ph_trip[1]) + 2'(ph_trip[2]);
   assign need_ok_start = quorum(n_start, oper_reg); // see RL18
   assign need_ok_trip = quorum(n_trip, oper_reg);

   always_comb begin
      gstart_next = {need_ok_start && !USER_BLOCK_IN, 2'b00}; // see RL2
      gtrip_next = need_ok_trip && !start_only_reg && !USER_BLOCK_IN; // see RL17
   end
   assign start_ev = gstart_next[2] && !gstart_reg[2];
   assign trip_ev = gtrip_next && !gtrip_reg;
   always_ff @(posedge CLK_SYS or negedge RST_N) begin
      if (!RST_N) begin
         gstart_reg <= 3'b000;
         gtrip_reg <= 1'b0;
      end else begin
         gstart_reg <= gstart_next;
         gtrip_reg <= gtrip_next;
      end
   end

   assign PHASE_A_START = ph_start[0] && !USER_BLOCK_IN;
   assign PHASE_B_START = ph_start[1] && !USER_BLOCK_IN;
   assign PHASE_C_START = ph_start[2] && !USER_BLOCK_IN;
   assign ANY_PHASE_START = gstart_reg[2];
   assign COMBINED_TRIP = gtrip_reg;
   assign IRQ = |(irq_stat_reg & irq_mask_reg);

   property p_start_only;
      @(posedge CLK_SYS) disable iff (!RST_N)
         start_only_reg |-> ##1 !COMBINED_TRIP;
   endproperty
   a_start_only: assert property (p_start_only) // see RL12
      else $error("Trip in start-only mode");

   property p_gen_trip;
      @(posedge CLK_SYS) disable iff (!RST_N)
         COMBINED_TRIP |-> $past(quorum(n_trip, oper_reg)) && $past(!USER_BLOCK_IN);
   endproperty
   a_gen_trip: assert property (p_gen_trip) // see RL3
      else $error("Combined trip without phase quorum");

   property p_block;
      @(posedge CLK_SYS) disable iff (!RST_N)
         USER_BLOCK_IN |-> !PHASE_A_START && !PHASE_B_START && !PHASE_C_START ##1 !COMBINED_TRIP;
   endproperty
   a_block: assert property (p_block) // see RL16
      else $error("Output active while blocked");

   property p_off;
      @(posedge CLK_SYS) disable iff (!RST_N)
         oper_reg == uv_pkg::OP_OFF |=> !ANY_PHASE_START;
   endproperty
   a_off: assert property (p_off) // see RL8
      else $error("General start while off");

   property p_any_start;
      @(posedge CLK_SYS) disable iff (!RST_N)
         oper_reg == uv_pkg::OP_ONE && |ph_start && !USER_BLOCK_IN |=> ANY_PHASE_START;
   endproperty
   a_any_start: assert property (p_any_start) // see RL2
      else $error("General start missing");

   property p_irq;
      @(posedge CLK_SYS) disable iff (!RST_N)
         trip_ev |=> irq_stat_reg[uv_pkg::IRQ_TRIP_BIT];
   endproperty
   a_irq: assert property (p_irq)
      else $error("Trip event not latched");
endmodule : undervoltage_element

// ===== uv_source.sv
module uv_source (
   input wire logic clk,
   output logic [uv_pkg::MAG_W-1:0] a_mag,
   output logic [uv_pkg::MAG_W-1:0] b_mag,
   output logic [uv_pkg::MAG_W-1:0] c_mag,
   output logic [uv_pkg::MAG_W-1:0] ab_mag,
   output logic [uv_pkg::MAG_W-1:0] bc_mag,
   output logic [uv_pkg::MAG_W-1:0] ca_mag
);
   timeunit 1ns;
   timeprecision 1ns;
   // Healthy network at nominal magnitude until told otherwise
   initial begin
      a_mag = uv_pkg::NOMINAL_DEF;
      b_mag = uv_pkg::NOMINAL_DEF;
      c_mag = uv_pkg::NOMINAL_DEF;
      ab_mag = uv_pkg::NOMINAL_DEF;
      bc_mag = uv_pkg::NOMINAL_DEF;
      ca_mag = uv_pkg::NOMINAL_DEF;
   end
   // A fresh fundamental result lands just after an edge, all six at once
   task automatic drive(input logic [15:0] pa, pb, pc, lab, lbc, lca);
      @(posedge clk);
      a_mag <= pa;
      b_mag <= pb;
      c_mag <= pc;
      ab_mag <= lab;
      bc_mag <= lbc;
      ca_mag <= lca;
   endtask : drive
endmodule : uv_source

// ===== test_undervoltage_element.sv
module test_undervoltage_element;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] NOM = 16'h2710;
   localparam logic [15:0] LOW = 16'h1388;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic user_block_in = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000;
   logic [31:0] prdata;
   logic pready, pslverr, phase_a_start, phase_b_start, phase_c_start;
   logic any_phase_start, combined_trip, irq;
   logic [15:0] a_mag, b_mag, c_mag, ab_mag, bc_mag, ca_mag;
   int errors = 0;
   int checks = 0;
   always #10 clk_sys = ~clk_sys;
   uv_source SRC (.clk(clk_sys), .a_mag(a_mag), .b_mag(b_mag), .c_mag(c_mag),
      .ab_mag(ab_mag), .bc_mag(bc_mag), .ca_mag(ca_mag));
   undervoltage_element #(.TICK_CYCLES(10)) DUT (.CLK_SYS(clk_sys), .RST_N(rst_n),
      .PHASE_A_FUND_MAG(a_mag), .PHASE_B_FUND_MAG(b_mag), .PHASE_C_FUND_MAG(c_mag),
      .PAIR_AB_FUND_MAG(ab_mag), .PAIR_BC_FUND_MAG(bc_mag), .PAIR_CA_FUND_MAG(ca_mag),
      .USER_BLOCK_IN(user_block_in), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
      .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
      .PSLVERR(pslverr), .PHASE_A_START(phase_a_start), .PHASE_B_START(phase_b_start),
      .PHASE_C_START(phase_c_start), .ANY_PHASE_START(any_phase_start),
      .COMBINED_TRIP(combined_trip), .IRQ(irq));
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic test_done();
      $display("checks %0d errors %0d", checks, errors);
      if (errors == 0 && checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : test_done
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge clk_sys);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'b1;
      do begin
         @(posedge clk_sys);
         n++;
         if (n > 50) begin
            errors++;
            test_done();
         end
      end while (pready !== 1'b1);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic err;
      apb(1'b1, a, d, rd, err);
   endtask : wr
   task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
      logic [31:0] rd;
      logic err;
      apb(1'b0, a, 32'h0000_0000, rd, err);
      check(rd, exp);
   endtask : rd_check
   function automatic logic [31:0] oper(input uv_pkg::oper_t sel, input logic so,
                                        input logic ll);
      return {28'h000_0000, ll, so, sel};
   endfunction : oper
   task automatic settle();
      repeat (4) @(posedge clk_sys);
      #1;
   endtask : settle
   task automatic starts(input logic [2:0] exp_ph, input logic exp_any);
      check(32'({phase_a_start, phase_b_start, phase_c_start}), 32'(exp_ph));
      check(32'(any_phase_start), 32'(exp_any));
   endtask : starts
   task automatic wait_trip(output int n);
      n = 0;
      while (combined_trip !== 1'b1) begin
         @(posedge clk_sys);
         #1;
         n++;
         if (n > 700) begin
            errors++;
            test_done();
         end
      end
   endtask : wait_trip
   task automatic test_registers();
      logic [31:0] rd;
      logic err;
      starts(3'b000, 1'b0);
      check(32'(combined_trip), 32'h0000_0000);
      rd_check(uv_pkg::OFS_OPER, 32'h0000_0008);
      rd_check(uv_pkg::OFS_START, 32'h0000_005A);
      rd_check(uv_pkg::OFS_BLOCK, 32'h0000_000A);
      rd_check(uv_pkg::OFS_HYST, 32'h0000_0005);
      rd_check(uv_pkg::OFS_DELAY, 32'h0000_0064);
      wr(uv_pkg::OFS_BLOCK, 32'h0000_0019);
      rd_check(uv_pkg::OFS_BLOCK, 32'h0000_0014);
      wr(uv_pkg::OFS_BLOCK, 32'h0000_000A);
      wr(8'h40, 32'h0000_1234);
      apb(1'b0, 8'h40, 32'h0000_0000, rd, err);
      check(rd, 32'h0000_0000);
      check(32'(err), 32'h0000_0001);
      // Selector off: a deep sag must not start anything
      SRC.drive(NOM, NOM, NOM, LOW, NOM, NOM);
      settle();
      starts(3'b000, 1'b0);
      $display("test_registers done");
   endtask : test_registers
   task automatic test_start();
      wr(uv_pkg::OFS_OPER, oper(uv_pkg::OP_ONE, 1'b0, 1'b1));
      SRC.drive(LOW, LOW, LOW, LOW, 16'h01F4, NOM);
      settle();
      starts(3'b100, 1'b1);
      SRC.drive(NOM, NOM, NOM, 16'h23F0, NOM, LOW);
      settle();
      starts(3'b101, 1'b1);
      SRC.drive(NOM, NOM, NOM, 16'h2580, NOM, NOM);
      settle();
      starts(3'b000, 1'b0);
      wr(uv_pkg::OFS_OPER, oper(uv_pkg::OP_ONE, 1'b0, 1'b0));
      SRC.drive(NOM, LOW, NOM, LOW, NOM, LOW);
      settle();
      starts(3'b010, 1'b1);
      $display("test_start done");
   endtask : test_start
   task automatic test_quorum();
      wr(uv_pkg::OFS_OPER, oper(uv_pkg::OP_TWO, 1'b0, 1'b1));
      SRC.drive(NOM, NOM, NOM, LOW, NOM, NOM);
      settle();
      check(32'(any_phase_start), 32'h0000_0000);
      SRC.drive(NOM, NOM, NOM, LOW, LOW, NOM);
      settle();
      check(32'(any_phase_start), 32'h0000_0001);
      wr(uv_pkg::OFS_OPER, oper(uv_pkg::OP_ALL, 1'b0, 1'b1));
      settle();
      check(32'(any_phase_start), 32'h0000_0000);
      SRC.drive(NOM, NOM, NOM, LOW, LOW, LOW);
      settle();
      check(32'(any_phase_start), 32'h0000_0001);
      SRC.drive(NOM, NOM, NOM, NOM, NOM, NOM);
      $display("test_quorum done");
   endtask : test_quorum
   task automatic test_trip();
      int n;
      logic [31:0] rd;
      logic err;
      wr(uv_pkg::OFS_OPER, oper(uv_pkg::OP_ONE, 1'b0, 1'b1));
      wr(uv_pkg::OFS_DELAY, 32'h0000_0032);
      wr(uv_pkg::OFS_IRQ_MASK, 32'h0000_0000);
      wr(uv_pkg::OFS_IRQ_STAT, 32'h0000_0003);
      SRC.drive(NOM, NOM, NOM, LOW, NOM, NOM);
      settle();
      rd_check(uv_pkg::OFS_IRQ_STAT, 32'h0000_0001);
      check(32'(irq), 32'h0000_0000);
      wr(uv_pkg::OFS_IRQ_MASK, 32'h0000_0001);
      #1;
      check(32'(irq), 32'h0000_0001);
      // Interrupted start restarts the whole delay
      repeat (280) @(posedge clk_sys);
      SRC.drive(NOM, NOM, NOM, NOM, NOM, NOM);
      repeat (5) @(posedge clk_sys);
      SRC.drive(NOM, NOM, NOM, 16'h07D0, NOM, NOM);
      wait_trip(n);
      check(32'(n >= 501 && n <= 512), 32'h0000_0001);
      apb(1'b0, uv_pkg::OFS_STATUS, 32'h0000_0000, rd, err);
      check(rd & 32'h0000_007C, 32'h0000_004C);
      check(32'(err), 32'h0000_0000);
      user_block_in <= 1'b1;
      #1;
      check(32'(phase_a_start), 32'h0000_0000);
      settle();
      starts(3'b000, 1'b0);
      check(32'(combined_trip), 32'h0000_0000);
      @(posedge clk_sys);
      user_block_in <= 1'b0;
      SRC.drive(NOM, NOM, NOM, NOM, NOM, NOM);
      wr(uv_pkg::OFS_IRQ_STAT, 32'h0000_0003);
      rd_check(uv_pkg::OFS_IRQ_STAT, 32'h0000_0000);
      check(32'(irq), 32'h0000_0000);
      $display("test_trip done");
   endtask : test_trip
   task automatic test_start_only();
      wr(uv_pkg::OFS_OPER, oper(uv_pkg::OP_ONE, 1'b1, 1'b1));
      SRC.drive(NOM, NOM, NOM, NOM, LOW, NOM);
      repeat (600) @(posedge clk_sys);
      #1;
      starts(3'b010, 1'b1);
      check(32'(combined_trip), 32'h0000_0000);
      $display("test_start_only done");
   endtask : test_start_only
   initial begin
      repeat (3) @(posedge clk_sys);
      rst_n <= 1'b1;
      settle();
      test_registers();
      test_start();
      test_quorum();
      test_trip();
      test_start_only();
      test_done();
   end
endmodule : test_undervoltage_element
